/* src/cpm_top.sv */
// Purpose: video output port: sense/adjust pin, sync outputs, pixel clock and data
// Assumes: clk 200 MHz; pixel clock made by dividing clk by two
// Notes: pclk is the pin's input side and clocks the internal converter latch
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "cpm_consts.svh"
module cpm_top (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                ce,
	input  wire cpm_pkg::cpm_bus_t   bus,
	output logic [15:0]              rdata,
	input  wire logic [7:0]          pix_in,
	input  wire logic                monitor_sense_n,
	output logic                     dac_full_scale_set,
	input  wire logic                pclk,
	output logic                     pclk_out,
	output logic                     pclk_oe,
	output cpm_pkg::cpm_video_t      video,
	output logic [7:0]               dac_word
);
	localparam cpm_pkg::cpm_state_t RST_ST = '{
		misc:     `CPM_RST_MISC,
		dac_sel:  1'b0,
		aux_on:   1'b0,
		htotal:   `CPM_RST_HTOTAL,
		hs_start: `CPM_RST_HS_START,
		hs_width: `CPM_RST_HS_WIDTH,
		vtotal:   `CPM_RST_VTOTAL,
		vs_start: `CPM_RST_VS_START,
		vs_width: `CPM_RST_VS_WIDTH,
		hcnt:     12'h000,
		vcnt:     12'h000,
		h_win:    1'b0,
		v_win:    1'b0,
		div:      1'b0,
		pclk_out: 1'b0,
		pclk_oe:  1'b1,
		adj_en:   1'b1,
		sense:    1'b0,
		req:      1'b0,
		xfer:     8'h00,
		rdata:    16'h0000,
		video:    '0
	};

	cpm_pkg::cpm_state_t st;
	cpm_pkg::cpm_state_t next_st;
	logic                sense_q;
	logic                ack_q;
	logic                ack_raw;
	logic                tick;
	logic [12:0]         h_pos;
	logic [12:0]         v_pos;
	logic [12:0]         hs_end;
	logic [12:0]         vs_end;
	logic [15:0]         rd_mux;

	cpm_sync3 u_sense_sync (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.d    (monitor_sense_n),
		.q    (sense_q)
	);

	cpm_sync3 u_ack_sync (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.d    (ack_raw),
		.q    (ack_q)
	);

	cpm_dac_latch u_dac (
		.pclk      (pclk),
		.rstn      (rstn),
		.req       (st.req),
		.xfer_word (st.xfer),
		.dac_word  (dac_word),
		.ack       (ack_raw)
	);

	always_comb begin
		h_pos  = {1'b0, st.hcnt};
		v_pos  = {1'b0, st.vcnt};
		hs_end = {1'b0, st.hs_start} + {1'b0, st.hs_width};
		vs_end = {1'b0, st.vs_start} + {1'b0, st.vs_width};
		tick   = ~st.div;
		rd_mux = 16'h0000;
		unique case (bus.addr)
			`CPM_ADDR_IN_STAT: begin
				rd_mux[`CPM_SENSE_BIT] = st.sense;
			end
			`CPM_ADDR_MISC_RD: begin
				rd_mux[7:0] = st.misc;
			end
			`CPM_ADDR_DAC_SEL: begin
				rd_mux[`CPM_SEL_BIT] = st.dac_sel;
			end
			`CPM_ADDR_AUX_CTRL: begin
				rd_mux[`CPM_SEL_BIT] = st.aux_on;
			end
			`CPM_ADDR_HTOTAL: begin
				rd_mux[11:0] = st.htotal;
			end
			`CPM_ADDR_HS_START: begin
				rd_mux[11:0] = st.hs_start;
			end
			`CPM_ADDR_HS_WIDTH: begin
				rd_mux[11:0] = st.hs_width;
			end
			`CPM_ADDR_VTOTAL: begin
				rd_mux[11:0] = st.vtotal;
			end
			`CPM_ADDR_VS_START: begin
				rd_mux[11:0] = st.vs_start;
			end
			`CPM_ADDR_VS_WIDTH: begin
				rd_mux[11:0] = st.vs_width;
			end
			`CPM_ADDR_STATUS: begin
				rd_mux[2:0] = {st.req ^ ack_q, st.v_win, st.h_win};
			end
			default: begin
				rd_mux = 16'h0000;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.rdata = 16'h0000;
		if (bus.rd) begin
			next_st.rdata = rd_mux;
		end
		if (bus.wr) begin
			unique case (bus.addr)
				`CPM_ADDR_IN_STAT: begin
					next_st.misc = bus.wdata[7:0];
				end
				`CPM_ADDR_DAC_SEL: begin
					next_st.dac_sel = bus.wdata[`CPM_SEL_BIT];
				end
				`CPM_ADDR_AUX_CTRL: begin
					next_st.aux_on = bus.wdata[`CPM_SEL_BIT];
				end
				`CPM_ADDR_HTOTAL: begin
					next_st.htotal = bus.wdata[11:0];
				end
				`CPM_ADDR_HS_START: begin
					next_st.hs_start = bus.wdata[11:0];
				end
				`CPM_ADDR_HS_WIDTH: begin
					next_st.hs_width = bus.wdata[11:0];
				end
				`CPM_ADDR_VTOTAL: begin
					next_st.vtotal = bus.wdata[11:0];
				end
				`CPM_ADDR_VS_START: begin
					next_st.vs_start = bus.wdata[11:0];
				end
				`CPM_ADDR_VS_WIDTH: begin
					next_st.vs_width = bus.wdata[11:0];
				end
				default: begin
					next_st.misc = st.misc;
				end
			endcase
		end
		// dual-use pin: sense only in external converter mode
		next_st.adj_en   = ~st.dac_sel;
		next_st.sense    = st.dac_sel ? sense_q : 1'b0;
		// pixel clock divider, pin driven unless auxiliary mode
		next_st.div      = ~st.div;
		next_st.pclk_out = ~st.div;
		next_st.pclk_oe  = ~st.aux_on;
		if (tick) begin
			next_st.video.pix = pix_in;
			next_st.h_win = (h_pos >= {1'b0, st.hs_start}) && (h_pos < hs_end);
			next_st.v_win = (v_pos >= {1'b0, st.vs_start}) && (v_pos < vs_end);
			if (st.hcnt >= st.htotal) begin
				next_st.hcnt = 12'h000;
				if (st.vcnt >= st.vtotal) begin
					next_st.vcnt = 12'h000;
				end else begin
					next_st.vcnt = st.vcnt + 12'h001;
				end
			end else begin
				next_st.hcnt = st.hcnt + 12'h001;
			end
			// hand the pixel to the converter latch when the last one is taken
			if (st.aux_on && (st.req == ack_q)) begin
				next_st.xfer = pix_in;
				next_st.req  = ~st.req;
			end
		end
		next_st.video.hsync = next_st.h_win ^ next_st.misc[`CPM_HPOL_BIT];
		next_st.video.vsync = next_st.v_win ^ next_st.misc[`CPM_VPOL_BIT];
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= RST_ST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign rdata              = st.rdata;
	assign dac_full_scale_set = st.adj_en;
	assign pclk_out           = st.pclk_out;
	assign pclk_oe            = st.pclk_oe;
	assign video              = st.video;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn || !ce);

	property p_adjust_mode;
		st.dac_sel ##1 st.dac_sel |-> !dac_full_scale_set;
	endproperty
	a_adjust_mode: assert property (p_adjust_mode) else $error("adjust pin on in sense mode");

	property p_sense_read;
		(bus.rd && bus.addr == `CPM_ADDR_IN_STAT && st.dac_sel)
			|=> rdata[`CPM_SENSE_BIT] == $past(st.sense);
	endproperty
	a_sense_read: assert property (p_sense_read) else $error("sense bit wrong on read");

	property p_vs_pol;
		(!st.v_win && st.misc[`CPM_VPOL_BIT]) [*2] |-> video.vsync;
	endproperty
	a_vs_pol: assert property (p_vs_pol) else $error("vsync idle level ignores polarity");

	property p_hs_pol;
		(!st.h_win && !st.misc[`CPM_HPOL_BIT]) [*2] |-> !video.hsync;
	endproperty
	a_hs_pol: assert property (p_hs_pol) else $error("hsync idle level ignores polarity");

	property p_hs_start;
		(tick && st.hs_width != 12'h000 && st.hcnt == st.hs_start
			&& bus.addr != `CPM_ADDR_IN_STAT)
			|=> video.hsync != st.misc[`CPM_HPOL_BIT];
	endproperty
	a_hs_start: assert property (p_hs_start) else $error("hsync not active at start");

	property p_pix_edge;
		!$stable(video.pix) |-> $rose(pclk_out);
	endproperty
	a_pix_edge: assert property (p_pix_edge) else $error("pixel data moved off rising edge");

	property p_pin_input;
		st.aux_on ##1 st.aux_on |-> !pclk_oe;
	endproperty
	a_pin_input: assert property (p_pin_input) else $error("pixel clock driven in aux mode");

	property p_pin_output;
		!st.aux_on ##1 !st.aux_on |-> pclk_oe ##1 pclk_out != $past(pclk_out);
	endproperty
	a_pin_output: assert property (p_pin_output) else $error("pixel clock not driven");

	property p_rdata_idle;
		!bus.rd |=> rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

	property p_adjust_on;
		!st.dac_sel ##1 !st.dac_sel |-> dac_full_scale_set;
	endproperty
	a_adjust_on: assert property (p_adjust_on) else $error("adjust pin off");

	property p_sense_off;
		!st.dac_sel |=> !st.sense;
	endproperty
	a_sense_off: assert property (p_sense_off) else $error("sense seen in adjust mode");

	property p_sense_track;
		st.dac_sel |=> st.sense == $past(sense_q);
	endproperty
	a_sense_track: assert property (p_sense_track) else $error("sense not tracking pin");

	property p_misc_write;
		bus.wr && bus.addr == `CPM_ADDR_IN_STAT |=> st.misc == $past(bus.wdata[7:0]);
	endproperty
	a_misc_write: assert property (p_misc_write) else $error("polarity write lost");

	property p_misc_read;
		bus.rd && bus.addr == `CPM_ADDR_MISC_RD |=> rdata == {8'h00, $past(st.misc)};
	endproperty
	a_misc_read: assert property (p_misc_read) else $error("polarity readback wrong");

	property p_vs_pol_hi;
		(!st.v_win && !st.misc[`CPM_VPOL_BIT]) [*2] |-> !video.vsync;
	endproperty
	a_vs_pol_hi: assert property (p_vs_pol_hi) else $error("vsync idle high");

	property p_hs_pol_lo;
		(!st.h_win && st.misc[`CPM_HPOL_BIT]) [*2] |-> video.hsync;
	endproperty
	a_hs_pol_lo: assert property (p_hs_pol_lo) else $error("hsync idle low");

	property p_hs_wr;
		bus.wr && bus.addr == `CPM_ADDR_HS_WIDTH |=> st.hs_width == $past(bus.wdata[11:0]);
	endproperty
	a_hs_wr: assert property (p_hs_wr) else $error("width write lost");

	property p_hs_end;
		(tick && st.hs_width != 12'h000 && {1'b0, st.hcnt} == hs_end)
			|=> video.hsync == st.misc[`CPM_HPOL_BIT];
	endproperty
	a_hs_end: assert property (p_hs_end) else $error("hsync not idle after width");

	property p_hs_none;
		st.hs_width == 12'h000 && !st.h_win |=> !st.h_win;
	endproperty
	a_hs_none: assert property (p_hs_none) else $error("sync window with zero width");

	property p_pix_hold;
		$rose(pclk_out) |=> $stable(video.pix);
	endproperty
	a_pix_hold: assert property (p_pix_hold) else $error("pixel data moved on falling edge");

	property p_send;
		(tick && st.aux_on && st.req == ack_q)
			|=> st.req != $past(st.req) && st.xfer == $past(pix_in);
	endproperty
	a_send: assert property (p_send) else $error("pixel not handed to converter");

	property p_send_hold;
		st.req != ack_q |=> $stable({st.req, st.xfer});
	endproperty
	a_send_hold: assert property (p_send_hold) else $error("handoff word moved");

	property p_no_send;
		!st.aux_on |=> $stable(st.req);
	endproperty
	a_no_send: assert property (p_no_send) else $error("handoff outside aux mode");

	c_hs_pulse: cover property ($rose(st.h_win) ##[1:400] $fell(st.h_win));
	c_sense_read: cover property (bus.rd && bus.addr == `CPM_ADDR_IN_STAT && st.sense);
	c_handoff: cover property (st.aux_on && $changed(ack_q));
	c_aux_entry: cover property ($fell(pclk_oe));
	c_vs_pulse: cover property ($rose(st.v_win));
endmodule

/* src/cpm_consts.svh */
// Purpose: constants for the pixel port block: offsets, fields, reset values
// Assumes: 10-bit register address, 16-bit register data
// Notes: included by cpm_top and by the self-checking bench
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

`define CPM_ADDR_IN_STAT    10'h03C2
`define CPM_ADDR_MISC_RD    10'h03CC
`define CPM_ADDR_DAC_SEL    10'h0300
`define CPM_ADDR_AUX_CTRL   10'h0302
`define CPM_ADDR_HTOTAL     10'h0304
`define CPM_ADDR_HS_START   10'h0306
`define CPM_ADDR_HS_WIDTH   10'h0308
`define CPM_ADDR_VTOTAL     10'h030A
`define CPM_ADDR_VS_START   10'h030C
`define CPM_ADDR_VS_WIDTH   10'h030E
`define CPM_ADDR_STATUS     10'h0310

`define CPM_SENSE_BIT       4
`define CPM_HPOL_BIT        6
`define CPM_VPOL_BIT        7
`define CPM_SEL_BIT         7

`define CPM_RST_MISC        8'h00
`define CPM_RST_HTOTAL      12'h031F
`define CPM_RST_HS_START    12'h0290
`define CPM_RST_HS_WIDTH    12'h0060
`define CPM_RST_VTOTAL      12'h020C
`define CPM_RST_VS_START    12'h01EA
`define CPM_RST_VS_WIDTH    12'h0002

`endif

/* src/cpm_pkg.sv */
// Purpose: types shared by the pixel port block
// Assumes: constants come from cpm_consts.svh
// Notes: all state of each module is one of these structs
package cpm_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [9:0]  addr;
		logic [15:0] wdata;
	} cpm_bus_t;

	typedef struct packed {
		logic [7:0] pix;
		logic       hsync;
		logic       vsync;
	} cpm_video_t;

	typedef struct packed {
		logic [7:0]  misc;
		logic        dac_sel;
		logic        aux_on;
		logic [11:0] htotal;
		logic [11:0] hs_start;
		logic [11:0] hs_width;
		logic [11:0] vtotal;
		logic [11:0] vs_start;
		logic [11:0] vs_width;
		logic [11:0] hcnt;
		logic [11:0] vcnt;
		logic        h_win;
		logic        v_win;
		logic        div;
		logic        pclk_out;
		logic        pclk_oe;
		logic        adj_en;
		logic        sense;
		logic        req;
		logic [7:0]  xfer;
		logic [15:0] rdata;
		cpm_video_t  video;
	} cpm_state_t;

	typedef struct packed {
		logic [7:0] word;
		logic       ack;
	} cpm_dac_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} cpm_sync_state_t;

endpackage

/* src/cpm_sync3.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d is asynchronous to clk
// Notes: q moves only when the second and third stages agree
`timescale 1ns/1ps
module cpm_sync3 (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic d,
	output logic      q
);
	cpm_pkg::cpm_sync_state_t st;
	cpm_pkg::cpm_sync_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign q = st.q;
endmodule

/* src/cpm_dac_latch.sv */
// Purpose: internal converter word latch clocked by the pixel clock pin
// Assumes: xfer_word is held stable from a req toggle until ack follows it
// Notes: rstn must be held over at least one pclk rising edge; reset is synchronous to pclk
`timescale 1ns/1ps
module cpm_dac_latch (
	input  wire logic       pclk,
	input  wire logic       rstn,
	input  wire logic       req,
	input  wire logic [7:0] xfer_word,
	output logic [7:0]      dac_word,
	output logic            ack
);
	cpm_pkg::cpm_dac_state_t st;
	cpm_pkg::cpm_dac_state_t next_st;
	logic                    req_q;

	cpm_sync3 u_req_sync (
		.clk  (pclk),
		.rstn (rstn),
		.ce   (1'b1),
		.d    (req),
		.q    (req_q)
	);

	always_comb begin
		next_st = st;
		// new word announced: take it and answer
		if (req_q != st.ack) begin
			next_st.word = xfer_word;
			next_st.ack  = req_q;
		end
	end

	always_ff @(posedge pclk) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dac_word = st.word;
	assign ack      = st.ack;
endmodule

/* verif/cpm_far_side.sv */
// Purpose: far side of the video port: monitor, link oscillator and capture latch
// Assumes: pclk_pin is the resolved level of the pixel clock pin
// Notes: link oscillator runs free at 15 ns, as an external pixel clock source does
`timescale 1ns/1ps
module cpm_far_side (
	input  wire logic                pclk_pin,
	input  wire cpm_pkg::cpm_video_t video,
	input  wire logic                present,
	output logic                     ext_clk,
	output logic                     monitor_sense_n,
	output logic [7:0]               cap
);
	initial begin
		ext_clk = 1'b0;
		// offset keeps link edges clear of system clock edges
		#1.3;
		forever #7.5 ext_clk = ~ext_clk;
	end

	// monitor pulls the sense line low when attached
	assign monitor_sense_n = ~present;

	initial cap = 8'h00;
	always @(negedge pclk_pin) begin
		cap <= video.pix;
	end
endmodule

/* verif/crt_pixel_port_mux_bench.sv */
// Purpose: self-checking bench for the video output port
// Assumes: register map and reset values as in cpm_consts.svh
// Notes: converter clock comes from the far side oscillator so its latch sees reset edges
`timescale 1ns/1ps
`include "cpm_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module crt_pixel_port_mux_bench;
	logic                clk;
	logic                rstn;
	logic                present;
	logic [7:0]          pix_in;
	cpm_pkg::cpm_bus_t   bus;
	logic [15:0]         rdata;
	logic                dac_full_scale_set;
	logic                pclk_out;
	logic                pclk_oe;
	cpm_pkg::cpm_video_t video;
	logic [7:0]          dac_word;
	logic [7:0]          cap;
	logic                ext_clk;
	logic                sense_n;
	wire                 pclk_pin;
	int                  n_mismatch;
	int                  comparisons;

	assign pclk_pin = pclk_oe ? pclk_out : ext_clk;

	cpm_top dut_u (.clk(clk), .rstn(rstn), .ce(1'b1), .bus(bus), .rdata(rdata),
		.pix_in(pix_in), .monitor_sense_n(sense_n),
		.dac_full_scale_set(dac_full_scale_set), .pclk(ext_clk), .pclk_out(pclk_out),
		.pclk_oe(pclk_oe), .video(video), .dac_word(dac_word));

	cpm_far_side far_u (.pclk_pin(pclk_pin), .video(video), .present(present),
		.ext_clk(ext_clk), .monitor_sense_n(sense_n), .cap(cap));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic finish_test();
		$display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
	endtask

	task automatic wr(input logic [9:0] a, input logic [15:0] v);
		@(posedge clk);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= v;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		@(posedge clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask

	task automatic t_regs();
		#1;
		`CHK(dac_full_scale_set, 1'b1)
		`CHK(pclk_oe, 1'b1)
		rd(`CPM_ADDR_MISC_RD, {8'h00, `CPM_RST_MISC});
		rd(`CPM_ADDR_HTOTAL, {4'h0, `CPM_RST_HTOTAL});
		rd(`CPM_ADDR_HS_START, {4'h0, `CPM_RST_HS_START});
		rd(`CPM_ADDR_HS_WIDTH, {4'h0, `CPM_RST_HS_WIDTH});
		rd(`CPM_ADDR_VTOTAL, {4'h0, `CPM_RST_VTOTAL});
		wr(`CPM_ADDR_MISC_RD, 16'h00C0);
		rd(`CPM_ADDR_MISC_RD, 16'h0000);
		rd(10'h0200, 16'h0000);
		$display("test regs done");
	endtask

	task automatic t_sense();
		present <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`CPM_ADDR_IN_STAT, 16'h0000);
		present <= 1'b0;
		wr(`CPM_ADDR_DAC_SEL, 16'h0080);
		repeat (10) @(posedge clk);
		#1;
		`CHK(dac_full_scale_set, 1'b0)
		rd(`CPM_ADDR_IN_STAT, 16'h0010);
		present <= 1'b1;
		repeat (10) @(posedge clk);
		rd(`CPM_ADDR_IN_STAT, 16'h0000);
		present <= 1'b0;
		$display("test sense done");
	endtask

	task automatic t_pixel();
		logic [7:0] p;
		logic [7:0] last;
		last = video.pix;
		`CHK(pclk_oe, 1'b1)
		for (int i = 0; i < 24; i++) begin
			@(posedge clk);
			p = pix_in;
			pix_in <= pix_in + 8'h13;
			#1;
			if (pclk_out === 1'b1) begin
				`CHK(video.pix, p)
			end else begin
				`CHK(video.pix, last)
				`CHK(cap, video.pix)
			end
			last = video.pix;
		end
		$display("test pixel done");
	endtask

	task automatic t_aux();
		int k;
		pix_in <= 8'hA5;
		wr(`CPM_ADDR_AUX_CTRL, 16'h0080);
		k = 0;
		while (pclk_oe !== 1'b0 && k < 20) begin
			@(posedge clk);
			#1;
			k++;
		end
		`CHK(pclk_oe, 1'b0)
		repeat (60) @(posedge clk);
		#1;
		`CHK(dac_word, 8'hA5)
		pix_in <= 8'h3C;
		repeat (60) @(posedge clk);
		#1;
		`CHK(dac_word, 8'h3C)
		wr(`CPM_ADDR_AUX_CTRL, 16'h0000);
		repeat (3) @(posedge clk);
		#1;
		`CHK(pclk_oe, 1'b1)
		$display("test aux done");
	endtask

	// count sync high cycles over one 128-cycle frame
	task automatic count_sync(output int h, output int v);
		h = 0;
		v = 0;
		repeat (300) @(posedge clk);
		repeat (128) begin
			@(posedge clk);
			#1;
			h += (video.hsync === 1'b1);
			v += (video.vsync === 1'b1);
		end
	endtask

	task automatic t_sync();
		int h;
		int v;
		logic [7:0] m;
		do_reset();
		wr(`CPM_ADDR_HTOTAL, 16'h000F);
		wr(`CPM_ADDR_HS_START, 16'h0004);
		wr(`CPM_ADDR_HS_WIDTH, 16'h0003);
		wr(`CPM_ADDR_VTOTAL, 16'h0003);
		wr(`CPM_ADDR_VS_START, 16'h0001);
		wr(`CPM_ADDR_VS_WIDTH, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			m = {i[1:0], 6'h00};
			wr(`CPM_ADDR_IN_STAT, {8'h00, m});
			rd(`CPM_ADDR_MISC_RD, {8'h00, m});
			count_sync(h, v);
			`CHK(h, m[6] ? 104 : 24)
			`CHK(v, m[7] ? 96 : 32)
		end
		wr(`CPM_ADDR_IN_STAT, 16'h0000);
		wr(`CPM_ADDR_HS_WIDTH, 16'h0000);
		wr(`CPM_ADDR_VS_WIDTH, 16'h0000);
		count_sync(h, v);
		`CHK(h, 0)
		`CHK(v, 0)
		rd(`CPM_ADDR_STATUS, 16'h0000);
		$display("test sync done");
	endtask

	initial begin
		#100000;
		n_mismatch++;
		$display("[FAIL] %0t run limit reached", $time);
		finish_test();
	end

	initial begin
		rstn = 1'b0;
		bus = '0;
		pix_in = 8'h00;
		present = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		do_reset();
		t_regs();
		t_sense();
		t_pixel();
		t_aux();
		t_sync();
		finish_test();
	end
endmodule
